// ===== ebpc_pkg.sv
// Package: register map, field positions and constants for the E1 test-pattern control block
package ebpc_pkg;
  // Register indices (printed offsets are not multiples of four)
  localparam logic [11:0] IDX_SWAP = 12'h121; // Path swap and error rate register
  localparam logic [11:0] IDX_CTRL = 12'h123; // Test pattern control and status
  localparam logic [11:0] IDX_IRQ_STAT = 12'h140; // Sticky event status
  localparam logic [11:0] IDX_IRQ_MASK = 12'h141; // Event mask
  // Byte addresses are four times the index
  localparam logic [13:0] ADR_SWAP = {IDX_SWAP, 2'b00};
  localparam logic [13:0] ADR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [13:0] ADR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [13:0] ADR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // Control register field positions
  localparam int B_TYPE = 7;
  localparam int B_INJ = 6;
  localparam int B_INV = 5;
  localparam int B_LOCK = 4;
  localparam int B_CHK_EN = 3;
  localparam int B_GEN_EN = 2;
  localparam int B_RX_SKIP = 1;
  localparam int B_TX_SKIP = 0;
  // Swap register field positions
  localparam int B_SWAP = 3;
  localparam int B_RATE_HI = 2;
  localparam int B_RATE_LO = 1;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SWAP_RST = 8'h00;
  // Error rate encodings
  localparam logic [1:0] RATE_1E3 = 2'h1;
  localparam logic [1:0] RATE_1E6 = 2'h2;
  localparam logic [19:0] CNT_1E3 = 20'h003E7; // 1000 bits minus one
  localparam logic [19:0] CNT_1E6 = 20'hF423F; // 1000000 bits minus one
  // Lock thresholds
  localparam logic [5:0] LOCK_MATCHES = 6'h20; // Consecutive matches to lock
  localparam logic [2:0] UNLOCK_ERRS = 3'h4; // Consecutive mismatches to unlock
  // Quasi-random signal: 20-stage sequence with long-zero suppression
  localparam int QRSS_TAP = 17;
  localparam int QRSS_LEN = 20;
  // Interrupt bit positions
  localparam int I_LOCK_GAIN = 0;
  localparam int I_LOCK_LOSS = 1;
  localparam int I_BIT_ERR = 2;
  // Checker states
  typedef enum logic [2:0] {
    CHK_OFF = 3'b001,
    CHK_HUNT = 3'b010,
    CHK_LOCKED = 3'b100
  } ebpc_chk_t;
endpackage

// ===== ebpc_top.sv
// Module: test-pattern generator, checker and framer bypass control with APB access
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module ebpc_top (
  input wire logic mclk_i, // 40 MHz system clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [15:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error for unmapped address
  output logic irq_o, // Level interrupt
  input wire logic bit_en_i, // One-cycle bit enable from the E1 bit clock divider
  input wire logic line_rx_i, // Bit arriving from the line
  input wire logic tx_bp_i, // Bit arriving from the transmit backplane
  input wire logic tx_framed_i, // Transmit framer output bit
  input wire logic rx_framed_i, // Receive framer output bit
  output logic line_tx_o, // Bit sent to the line
  output logic rx_bp_o, // Bit sent to the receive backplane
  output logic tx_skip_o, // Transmit framer bypassed
  output logic rx_skip_o // Receive framer bypassed
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_r; // First reset stage
  logic rst_n; // Released reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl_r; // Control bits, lock bit unused here
  logic [7:0] swap_r; // Swap and rate bits
  logic [2:0] stat_r; // Sticky events
  logic [2:0] mask_r; // Event mask
  logic lock_r; // Checker lock state
  logic inj_prev_r; // Previous inject level
  logic inj_pend_r; // Pending single error
  ebpc_pkg::ebpc_chk_t chk_r; // Checker state

  wire logic swap = swap_r[ebpc_pkg::B_SWAP];
  wire logic gen_en = ctrl_r[ebpc_pkg::B_GEN_EN];
  wire logic chk_en = ctrl_r[ebpc_pkg::B_CHK_EN];
  wire logic inv = ctrl_r[ebpc_pkg::B_INV];
  wire logic qrss = ctrl_r[ebpc_pkg::B_TYPE];
  wire logic [1:0] rate = {swap_r[ebpc_pkg::B_RATE_HI], swap_r[ebpc_pkg::B_RATE_LO]};

  // Access qualifiers
  wire logic acc = psel_i & penable_i;
  wire logic wr = acc & pwrite_i;
  wire logic hit_ctrl = paddr_i[13:0] == ebpc_pkg::ADR_CTRL && paddr_i[15:14] == 2'h0;
  wire logic hit_swap = paddr_i[13:0] == ebpc_pkg::ADR_SWAP && paddr_i[15:14] == 2'h0;
  wire logic hit_stat = paddr_i[13:0] == ebpc_pkg::ADR_IRQ_STAT && paddr_i[15:14] == 2'h0;
  wire logic hit_mask = paddr_i[13:0] == ebpc_pkg::ADR_IRQ_MASK && paddr_i[15:14] == 2'h0;
  wire logic hit_any = hit_ctrl | hit_swap | hit_stat | hit_mask;

  // Writable control registers; lock bit is never stored
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= ebpc_pkg::CTRL_RST;
      swap_r <= ebpc_pkg::SWAP_RST;
      mask_r <= 3'h0;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl_r <= pwdata_i[7:0] & ~(8'h01 << ebpc_pkg::B_LOCK);
      end
      if (hit_swap) begin
        swap_r <= pwdata_i[7:0] & 8'h0E;
      end
      if (hit_mask) begin
        mask_r <= pwdata_i[2:0];
      end
    end
  end

  // APB answer: zero wait, ready every cycle, error on unmapped access
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= 1'b1;
      pslverr_o <= psel_i & ~penable_i & ~hit_any;
      if (psel_i & ~penable_i & ~pwrite_i) begin
        if (hit_ctrl) begin
          prdata_o <= {24'h0, ctrl_r[7:5], lock_r, ctrl_r[3:0]};
        end else if (hit_swap) begin
          prdata_o <= {24'h0, swap_r};
        end else if (hit_stat) begin
          prdata_o <= {29'h0, stat_r};
        end else if (hit_mask) begin
          prdata_o <= {29'h0, mask_r};
        end else begin
          prdata_o <= 32'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generator
  logic [19:0] gen_r; // Generator shift register
  logic [19:0] rate_cnt_r; // Continuous error spacing counter

  // Next feedback bit of a sequence register
  function automatic logic fb(input logic [19:0] s, input logic q);
    fb = q ? s[ebpc_pkg::QRSS_TAP - 1] ^ s[ebpc_pkg::QRSS_LEN - 1] : s[13] ^ s[14];
  endfunction

  // Output bit of a sequence register, with zero suppression for quasi-random
  function automatic logic pbit(input logic [19:0] s, input logic q);
    pbit = q ? (s[19] | (s[18:4] == 15'h0)) : s[14];
  endfunction

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      gen_r <= 20'hFFFFF;
    end else if (bit_en_i && gen_en) begin
      gen_r <= {gen_r[18:0], fb(gen_r, qrss)};
    end
  end

  // Single error on rising inject edge, only while generating
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      inj_prev_r <= 1'b0;
      inj_pend_r <= 1'b0;
    end else begin
      inj_prev_r <= ctrl_r[ebpc_pkg::B_INJ];
      if (ctrl_r[ebpc_pkg::B_INJ] && !inj_prev_r && gen_en) begin
        inj_pend_r <= 1'b1;
      end else if (bit_en_i || !gen_en) begin
        inj_pend_r <= 1'b0;
      end
    end
  end

  // Continuous error rate counter
  wire logic rate_on = rate == ebpc_pkg::RATE_1E3 || rate == ebpc_pkg::RATE_1E6;
  wire logic [19:0] rate_top = rate == ebpc_pkg::RATE_1E3 ? ebpc_pkg::CNT_1E3 : ebpc_pkg::CNT_1E6;
  wire logic rate_hit = rate_on && rate_cnt_r >= rate_top;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_r <= 20'h0;
    end else if (!rate_on || !gen_en) begin
      rate_cnt_r <= 20'h0;
    end else if (bit_en_i) begin
      rate_cnt_r <= rate_hit ? 20'h0 : rate_cnt_r + 20'h1;
    end
  end

  // Generated bit with inversion and errors applied
  wire logic gen_bit = pbit(gen_r, qrss) ^ inv ^ inj_pend_r ^ rate_hit;

  // Output steering and framer bypass
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_tx_o <= 1'b0;
      rx_bp_o <= 1'b0;
      tx_skip_o <= 1'b0;
      rx_skip_o <= 1'b0;
    end else begin
      tx_skip_o <= ctrl_r[ebpc_pkg::B_TX_SKIP];
      rx_skip_o <= ctrl_r[ebpc_pkg::B_RX_SKIP];
      if (bit_en_i) begin
        line_tx_o <= (gen_en && !swap) ? gen_bit : tx_framed_i;
        rx_bp_o <= (gen_en && swap) ? gen_bit : rx_framed_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern checker: self-synchronising on the received stream
  logic [19:0] chk_sh_r; // Received history
  logic [5:0] match_cnt_r; // Consecutive matches
  logic [2:0] err_cnt_r; // Consecutive mismatches
  wire logic chk_in = (swap ? tx_bp_i : line_rx_i) ^ inv;
  wire logic chk_exp = qrss ? chk_sh_r[ebpc_pkg::QRSS_TAP - 1] ^ chk_sh_r[ebpc_pkg::QRSS_LEN - 1]
                            : chk_sh_r[13] ^ chk_sh_r[14];
  wire logic chk_ok = qrss ? 1'b1 : chk_in == chk_exp; // Zero suppression masks quasi-random compare

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      chk_r <= ebpc_pkg::CHK_OFF;
      chk_sh_r <= 20'h0;
      match_cnt_r <= 6'h0;
      err_cnt_r <= 3'h0;
      lock_r <= 1'b0;
    end else if (!chk_en) begin
      chk_r <= ebpc_pkg::CHK_OFF;
      lock_r <= 1'b0;
      match_cnt_r <= 6'h0;
      err_cnt_r <= 3'h0;
    end else if (bit_en_i) begin
      chk_sh_r <= {chk_sh_r[18:0], chk_in};
      case (chk_r)
        ebpc_pkg::CHK_OFF: begin
          chk_r <= ebpc_pkg::CHK_HUNT;
        end
        ebpc_pkg::CHK_HUNT: begin
          match_cnt_r <= chk_ok ? match_cnt_r + 6'h1 : 6'h0;
          if (chk_ok && match_cnt_r == ebpc_pkg::LOCK_MATCHES - 6'h1) begin
            chk_r <= ebpc_pkg::CHK_LOCKED;
            lock_r <= 1'b1;
            err_cnt_r <= 3'h0;
          end
        end
        ebpc_pkg::CHK_LOCKED: begin
          err_cnt_r <= chk_ok ? 3'h0 : err_cnt_r + 3'h1;
          if (!chk_ok && err_cnt_r == ebpc_pkg::UNLOCK_ERRS - 3'h1) begin
            chk_r <= ebpc_pkg::CHK_HUNT;
            lock_r <= 1'b0;
            match_cnt_r <= 6'h0;
          end
        end
        default: begin
          chk_r <= ebpc_pkg::CHK_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky events, write one to clear, set wins
  logic lock_d_r; // Lock delayed for edges
  wire logic [2:0] ev = {bit_en_i & lock_r & ~chk_ok, ~lock_r & lock_d_r, lock_r & ~lock_d_r};
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= 3'h0;
      lock_d_r <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      lock_d_r <= lock_r;
      stat_r <= (stat_r & ~(wr && hit_stat ? pwdata_i[2:0] : 3'h0)) | ev;
      irq_o <= |(stat_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_skip_follow: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ##1 tx_skip_o == $past(ctrl_r[ebpc_pkg::B_TX_SKIP]))
    else $error("tx skip output does not follow control");
  a_rskip_follow: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ##1 rx_skip_o == $past(ctrl_r[ebpc_pkg::B_RX_SKIP]))
    else $error("rx skip output does not follow control");
  a_inject_gated: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !gen_en |=> !inj_pend_r)
    else $error("injection pending without generator");
  a_inject_once: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (inj_pend_r && bit_en_i) |=> !inj_pend_r)
    else $error("injected error lasted more than one bit");
  a_line_idle: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (bit_en_i && swap && !gen_en) |=> line_tx_o == $past(tx_framed_i))
    else $error("line output not framer data when swapped");
  a_bp_gen: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (bit_en_i && gen_en && !swap) |=> rx_bp_o == $past(rx_framed_i))
    else $error("receive backplane carries pattern without swap");
  a_lock_off: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !chk_en |=> !lock_r)
    else $error("lock held while checker disabled");
  a_lock_read: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (psel_i && !penable_i && !pwrite_i && hit_ctrl) |=> prdata_o[ebpc_pkg::B_LOCK] == $past(lock_r))
    else $error("lock flag read mismatch");
  // Lock flag tracks the checker state exactly
  a_lock_state: assert property (@(posedge mclk_i) disable iff (!rst_n)
    lock_r == (chk_r == ebpc_pkg::CHK_LOCKED))
    else $error("lock flag disagrees with checker state");
  // One stray mismatch must not cost the lock
  a_one_miss_keeps: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (lock_r && chk_en && bit_en_i && !chk_ok && err_cnt_r == 3'h0) |=> lock_r)
    else $error("lock dropped after a single mismatch");
  // Generator off: both outputs carry framer data
  a_gen_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (bit_en_i && !gen_en) |=> line_tx_o == $past(tx_framed_i) && rx_bp_o == $past(rx_framed_i))
    else $error("pattern output while generator disabled");
  c_lock: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(lock_r));
  c_rate: cover property (@(posedge mclk_i) disable iff (!rst_n) rate_hit && bit_en_i);
  c_inject: cover property (@(posedge mclk_i) disable iff (!rst_n) inj_pend_r && swap);
  c_irq: cover property (@(posedge mclk_i) disable iff (!rst_n) $rose(irq_o));

endmodule // ebpc_top

// ===== ebpc_far_end.sv
// Far-side model: E1 bit timing and loopback of line and backplane paths
`timescale 1ns/1ps
module ebpc_far_end (
  input wire logic mclk_i, // System clock
  input wire logic corrupt_i, // Return every bit inverted
  input wire logic line_tx_i, // Bit from device to line
  input wire logic rx_bp_i, // Bit from device to receive backplane
  output logic bit_en_o, // One pulse per E1 bit
  output logic line_rx_o, // Bit returned from the line
  output logic tx_bp_o // Bit returned on transmit backplane
);
  ////////////////////////////////////////////////////////////////
  // Known levels before the first edge
  initial begin
    bit_en_o = 1'b0;
    line_rx_o = 1'b0;
    tx_bp_o = 1'b0;
  end
  // Bit pulse every second cycle keeps runs short
  always @(posedge mclk_i) begin
    bit_en_o <= ~bit_en_o;
  end
  // Loop both paths back, corrupted on command
  always @(posedge mclk_i) begin
    line_rx_o <= line_tx_i ^ corrupt_i;
    tx_bp_o <= rx_bp_i ^ corrupt_i;
  end
endmodule // ebpc_far_end

// ===== e1_bert_pattern_control_test.sv
// Self-checking bench for the test-pattern control block
`timescale 1ns/1ps
module e1_bert_pattern_control_test;
  logic mclk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Clock, reset, APB
  logic [15:0] paddr = 16'h0000; // APB address
  logic [31:0] pwdata = 32'h0, prdata, r; // APB data
  logic pready, pslverr, irq, bit_en, line_rx, tx_bp, line_tx, rx_bp, tx_skip, rx_skip, e;
  logic tx_framed = 1'b0, rx_framed = 1'b0, corrupt = 1'b0, src_sel = 1'b0, collecting = 1'b0;
  logic q[$]; // Captured output bits
  int fails = 0, samples_checked = 0, cycles = 0, v;
  int lo[4] = '{0, 4, 0, 0}; // Violation floor per rate code
  int hi[4] = '{0, 12, 3, 0}; // Violation ceiling per rate code
  ebpc_top u_ebpc_top (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .bit_en_i(bit_en), .line_rx_i(line_rx), .tx_bp_i(tx_bp),
    .tx_framed_i(tx_framed), .rx_framed_i(rx_framed), .line_tx_o(line_tx), .rx_bp_o(rx_bp),
    .tx_skip_o(tx_skip), .rx_skip_o(rx_skip));
  ebpc_far_end u_ebpc_far_end (.mclk_i(mclk), .corrupt_i(corrupt), .line_tx_i(line_tx),
    .rx_bp_i(rx_bp), .bit_en_o(bit_en), .line_rx_o(line_rx), .tx_bp_o(tx_bp));
  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Random framer bits, cycle ceiling, bit capture
  always @(posedge mclk) begin
    {tx_framed, rx_framed} <= 2'($urandom);
    cycles++;
    if (cycles == 60000) begin
      $display("[FAIL] %0t cycle ceiling reached", $time);
      fails++;
      close_out();
    end
    if (bit_en && collecting) q.push_back(src_sel ? rx_bp : line_tx);
  end
  task close_out();
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task chkr(input int n, input int a, input int b);
    samples_checked++;
    if (n < a || n > b) begin
      fails++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, n, a, b);
    end
  endtask
  // One APB transfer; waits for ready, the cycle ceiling ends a hang
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, {2'b00, a}, d);
  endtask
  task rd(input logic [13:0] a);
    apb(1'b0, {2'b00, a}, 32'h0);
  endtask
  // Reference model: count breaks of s[n] = s[n-14] ^ s[n-15] ^ inv
  task collect(input int n, input logic inv, output int nv);
    repeat (4) @(posedge mclk); // Let framer bits ahead of the pattern drain
    q.delete();
    collecting = 1'b1;
    for (int k = 0; k < 4 * n && q.size() < n; k++) @(posedge mclk);
    collecting = 1'b0;
    nv = 0;
    for (int i = 15; i < q.size(); i++) if (q[i] !== (q[i-14] ^ q[i-15] ^ inv)) nv++;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hD2C3A59E));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(ebpc_pkg::ADR_CTRL);
    chk(r, {24'h0, ebpc_pkg::CTRL_RST});
    rd(ebpc_pkg::ADR_SWAP);
    chk(r, {24'h0, ebpc_pkg::SWAP_RST});
    // Unmapped place: error, reads zero
    apb(1'b1, 16'h0600, $urandom);
    chk({31'h0, e}, 32'h1);
    rd(14'h0600);
    chk({r[30:0], e}, 32'h1);
    // Swap register keeps bits 3:1 only
    wr(ebpc_pkg::ADR_SWAP, 32'h0F);
    rd(ebpc_pkg::ADR_SWAP);
    chk(r, 32'h0E);
    // Lock flag ignores writes; skip levels follow
    wr(ebpc_pkg::ADR_CTRL, 32'h13);
    rd(ebpc_pkg::ADR_CTRL);
    chk(r, 32'h03);
    repeat (3) @(posedge mclk);
    chk({30'h0, rx_skip, tx_skip}, 32'h3);
    wr(ebpc_pkg::ADR_CTRL, 32'h01);
    repeat (3) @(posedge mclk);
    chk({30'h0, rx_skip, tx_skip}, 32'h1);
    // Inject edge while generator off must be lost
    wr(ebpc_pkg::ADR_CTRL, 32'h40);
    // Every swap and invert combination
    for (int c = 0; c < 4; c++) begin
      src_sel = c[0];
      wr(ebpc_pkg::ADR_CTRL, 32'h0);
      wr(ebpc_pkg::ADR_SWAP, {28'h0, c[0], 3'b000});
      wr(ebpc_pkg::ADR_IRQ_STAT, 32'h7);
      wr(ebpc_pkg::ADR_CTRL, {26'h0, c[1], 5'b01100});
      collect(200, c[1], v);
      chkr(v, 0, 0);
      rd(ebpc_pkg::ADR_CTRL);
      chk(r, {26'h0, c[1], 5'b11100});
      fork
        collect(200, c[1], v);
        begin
          repeat (100) @(posedge mclk);
          wr(ebpc_pkg::ADR_CTRL, {25'h0, 1'b1, c[1], 5'b01100});
        end
      join
      chkr(v, 3, 3);
      rd(ebpc_pkg::ADR_IRQ_STAT);
      chk(r & 32'h5, 32'h5);
    end
    // Corrupted return drops lock; interrupt mask and clear
    wr(ebpc_pkg::ADR_IRQ_STAT, 32'h7);
    corrupt <= 1'b1;
    repeat (80) @(posedge mclk);
    rd(ebpc_pkg::ADR_CTRL);
    chk({31'h0, r[4]}, 32'h0);
    wr(ebpc_pkg::ADR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(ebpc_pkg::ADR_IRQ_MASK, 32'h2);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(ebpc_pkg::ADR_IRQ_STAT, 32'h2);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    corrupt <= 1'b0;
    // Quasi-random type breaks the fifteen-stage recurrence
    src_sel = 1'b0;
    wr(ebpc_pkg::ADR_CTRL, 32'h0);
    wr(ebpc_pkg::ADR_SWAP, 32'h0);
    wr(ebpc_pkg::ADR_CTRL, 32'h8C);
    collect(200, 1'b0, v);
    chkr(v, 1, 1000);
    rd(ebpc_pkg::ADR_CTRL);
    chk({31'h0, r[4]}, 32'h1);
    // Every error-rate code
    for (int rr = 0; rr < 4; rr++) begin
      wr(ebpc_pkg::ADR_CTRL, 32'h0);
      wr(ebpc_pkg::ADR_SWAP, {29'h0, 2'(rr), 1'b0});
      wr(ebpc_pkg::ADR_CTRL, 32'h0C);
      collect(3000, 1'b0, v);
      chkr(v, lo[rr], hi[rr]);
    end
    close_out();
  end
endmodule // e1_bert_pattern_control_test
